/* File: design/ccsr_pkg.sv */
// Package for the processor control and status register block
package ccsr_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int PC_W   = 20;
  localparam int PCLO_W = 16;
  localparam int PCHI_W = 4;
  localparam int SW_W   = 16;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [PCHI_W-1:0] PC_HI_RST = 4'h0;
  localparam logic [SW_W-1:0]   SW_RST    = 16'h0000;

  // ---------------------------------------------------------------
  // Status word bit positions (full 16-bit word)
  // ---------------------------------------------------------------
  localparam int BIT_CY  = 0;
  localparam int BIT_PV  = 2;
  localparam int BIT_IE  = 3;
  localparam int BIT_AC  = 4;
  localparam int BIT_RSS = 5;
  localparam int BIT_Z   = 6;
  localparam int BIT_S   = 7;
  localparam int BIT_BK0 = 12;
  localparam int BIT_BK2 = 14;
  localparam int BIT_UF  = 15;
  // Implemented bits; others read zero and ignore writes
  localparam logic [SW_W-1:0] SW_IMPL = 16'hf0fd;

  // ---------------------------------------------------------------
  // AHB-Lite register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADR_SW_LO = 8'h00;
  localparam logic [7:0] ADR_SW_HI = 8'h04;
  localparam logic [7:0] ADR_PC    = 8'h08;
  localparam logic [7:0] ADR_SP    = 8'h0c;
  localparam logic [7:0] ADR_MAP   = 8'h10;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

  // ---------------------------------------------------------------
  // Stack pointer and register mapping
  // ---------------------------------------------------------------
  localparam int SP_W = 24;
  localparam logic [SP_W-1:0] SP_STEP = 24'h000002;
  localparam logic [2:0] RS0_A = 3'h1, RS0_X = 3'h0, RS0_B = 3'h3, RS0_C = 3'h2;
  localparam logic [2:0] RS1_A = 3'h5, RS1_X = 3'h4, RS1_B = 3'h7, RS1_C = 3'h6;
  localparam logic [1:0] RS0_AX = 2'h0, RS0_BC = 2'h1, RS1_AX = 2'h2, RS1_BC = 2'h3;

  // Flag update packet from the execution datapath
  typedef struct packed {
    logic cy_we;  logic cy;
    logic pv_we;  logic pv;
    logic ac_we;  logic ac;
    logic z_we;   logic z;
    logic s_we;   logic s;
  } ccsr_flags_t;

  // Arithmetic result packet used to derive flags in hardware
  typedef struct packed {
    logic       valid;   // Derive flags from this result
    logic       wide;    // 16-bit operation
    logic       arith;   // Overflow rule instead of parity
    logic       shift16; // 16-bit shift: parity on low byte only
    logic [15:0] res;
    logic       cy_out;
    logic       cy_msb;  // Carry into the MSB
    logic       c3;      // Carry out of / borrow into bit 3
  } ccsr_alu_t;

  // Sequencer operations that move the whole status word
  typedef enum logic [2:0] {
    SEQ_NONE, SEQ_PUSH, SEQ_POP, SEQ_CS_SAVE, SEQ_CS_RESTORE
  } ccsr_seq_t;

endpackage : ccsr_pkg

/* File: design/ccsr_top.sv */
// Processor control registers: program counter, status word, stack moves
//
// The AHB-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ccsr_top
  import ccsr_pkg::*;
(
  // Clock and reset
  input  wire logic              CLK_I,
  input  wire logic              RESET_I,
  input  wire logic              CE_I,
  // Reset vector and program counter control
  input  wire logic [PCLO_W-1:0] RST_VECTOR_I,
  input  wire logic              FETCH_I,
  input  wire logic [2:0]        FETCH_LEN_I,
  input  wire logic              BRANCH_I,
  input  wire logic [PC_W-1:0]   BRANCH_TARGET_I,
  // Datapath flag updates
  input  wire ccsr_flags_t       FLAGS_I,
  input  wire ccsr_alu_t         ALU_I,
  input  wire logic              HALF_WE_LO_I,
  input  wire logic              HALF_WE_HI_I,
  input  wire logic [7:0]        HALF_DATA_I,
  input  wire logic              BIT_WE_I,
  input  wire logic [3:0]        BIT_SEL_I,
  input  wire logic              BIT_VAL_I,
  input  wire logic              EI_I,
  input  wire logic              DI_I,
  input  wire logic              BANK_WE_I,
  input  wire logic [2:0]        BANK_I,
  // Interrupt and context sequencing
  input  wire ccsr_seq_t         SEQ_I,
  input  wire logic              INT_ACK_I,
  input  wire logic [SW_W-1:0]   RESTORE_I,
  input  wire logic              SP_LOAD_I,
  input  wire logic [SP_W-1:0]   SP_I,
  input  wire logic              NMI_REQ_I,
  input  wire logic              MACRO_REQ_I,
  input  wire logic              MASKABLE_REQ_I,
  // AHB-Lite slave
  input  wire logic              HSEL,
  input  wire logic [7:0]        HADDR,
  input  wire logic [1:0]        HTRANS,
  input  wire logic              HWRITE,
  input  wire logic [2:0]        HSIZE,
  input  wire logic [31:0]       HWDATA,
  input  wire logic              HREADY,
  output logic      [31:0]       HRDATA,
  output logic                   HREADYOUT,
  output logic                   HRESP,
  // State outputs
  output logic      [PC_W-1:0]   PC_O,
  output logic      [SW_W-1:0]   STATUS_WORD_O,
  output logic      [SP_W-1:0]   STACK_PTR_O,
  output logic                   STACK_WE_O,
  output logic      [SW_W-1:0]   STACK_DATA_O,
  output logic                   RP3_WE_O,
  output logic                   INT_ACCEPT_O,
  output logic      [2:0]        MAP_A_O,
  output logic      [2:0]        MAP_X_O,
  output logic      [2:0]        MAP_B_O,
  output logic      [2:0]        MAP_C_O,
  output logic      [1:0]        MAP_AX_O,
  output logic      [1:0]        MAP_BC_O
);

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [PC_W-1:0] pc;
  logic [SW_W-1:0] sw;
  logic [SP_W-1:0] sp;
  logic            vec_pend;
  logic [SW_W-1:0] next_sw;
  logic            bus_we;
  logic [7:0]      bus_adr;
  logic            parity_even;
  logic [7:0]      par_src;
  logic            res_zero;
  logic            res_sign;

  // ---------------------------------------------------------------
  // Program counter
  // ---------------------------------------------------------------
  // Vector fetch happens in the first enabled cycle after reset release,
  // since an async reset may only load constants.
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      pc       <= {PCHI_W'(0), PCLO_W'(0)};
      vec_pend <= 1'b1;
    end else if (CE_I) begin
      if (vec_pend) begin
        pc       <= {PC_HI_RST, RST_VECTOR_I};
        vec_pend <= 1'b0;
      end else if (BRANCH_I) begin
        pc <= BRANCH_TARGET_I;
      end else if (FETCH_I) begin
        pc <= pc + PC_W'(FETCH_LEN_I);
      end
    end
  end

  // ---------------------------------------------------------------
  // Flag derivation from an operation result
  // ---------------------------------------------------------------
  assign par_src     = ALU_I.res[7:0];
  assign res_zero    = ALU_I.wide ? (ALU_I.res == 16'h0000) : (ALU_I.res[7:0] == 8'h00);
  assign res_sign    = ALU_I.wide ? ALU_I.res[15] : ALU_I.res[7];
  // Parity over low byte; full word only for 16-bit non-shift logic ops
  assign parity_even = (ALU_I.wide && !ALU_I.shift16) ? ~(^ALU_I.res) : ~(^par_src);

  // ---------------------------------------------------------------
  // Status word next value; sequencer beats bus beats datapath
  // ---------------------------------------------------------------
  always_comb begin
    next_sw = sw;
    if (FLAGS_I.cy_we) next_sw[BIT_CY] = FLAGS_I.cy;
    if (FLAGS_I.pv_we) next_sw[BIT_PV] = FLAGS_I.pv;
    if (FLAGS_I.ac_we) next_sw[BIT_AC] = FLAGS_I.ac;
    if (FLAGS_I.z_we)  next_sw[BIT_Z]  = FLAGS_I.z;
    if (FLAGS_I.s_we)  next_sw[BIT_S]  = FLAGS_I.s;
    if (ALU_I.valid) begin
      next_sw[BIT_CY] = ALU_I.cy_out;
      next_sw[BIT_PV] = ALU_I.arith ? (ALU_I.cy_msb ^ ALU_I.cy_out)
                                    : parity_even;
      next_sw[BIT_AC] = ALU_I.c3;
      next_sw[BIT_Z]  = res_zero;
      next_sw[BIT_S]  = res_sign;
    end
    if (HALF_WE_LO_I) next_sw[7:0]  = HALF_DATA_I;
    if (HALF_WE_HI_I) next_sw[15:8] = HALF_DATA_I;
    if (BIT_WE_I) next_sw[BIT_SEL_I] = BIT_VAL_I;
    if (BANK_WE_I) next_sw[BIT_BK2:BIT_BK0] = BANK_I;
    if (EI_I) next_sw[BIT_IE] = 1'b1;
    if (DI_I) next_sw[BIT_IE] = 1'b0;
    if (bus_we && bus_adr == ADR_SW_LO) next_sw[7:0]  = HWDATA[7:0];
    if (bus_we && bus_adr == ADR_SW_HI) next_sw[15:8] = HWDATA[7:0];
    if (SEQ_I == SEQ_POP || SEQ_I == SEQ_CS_RESTORE) next_sw = RESTORE_I;
    if (INT_ACK_I) next_sw[BIT_IE] = 1'b0;
    next_sw = next_sw & SW_IMPL;
  end

  // Status word register
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) sw <= SW_RST;
    else if (CE_I) sw <= next_sw;
  end

  // ---------------------------------------------------------------
  // Stack pointer and save strobes
  // ---------------------------------------------------------------
  // Push writes the old word (before this cycle's ack clears IE)
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      sp           <= '0;
      STACK_WE_O   <= 1'b0;
      STACK_DATA_O <= SW_RST;
      RP3_WE_O     <= 1'b0;
    end else if (CE_I) begin
      STACK_WE_O <= SEQ_I == SEQ_PUSH;
      RP3_WE_O   <= SEQ_I == SEQ_CS_SAVE;
      if (SEQ_I == SEQ_PUSH || SEQ_I == SEQ_CS_SAVE) STACK_DATA_O <= sw;
      if (SP_LOAD_I) sp <= SP_I;
      else if (SEQ_I == SEQ_PUSH) sp <= sp - SP_STEP;
      else if (SEQ_I == SEQ_POP)  sp <= sp + SP_STEP;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt gate and register-set mapping
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      INT_ACCEPT_O <= 1'b0;
      MAP_A_O <= RS0_A; MAP_X_O <= RS0_X; MAP_B_O <= RS0_B; MAP_C_O <= RS0_C;
      MAP_AX_O <= RS0_AX; MAP_BC_O <= RS0_BC;
    end else if (CE_I) begin
      INT_ACCEPT_O <= NMI_REQ_I | MACRO_REQ_I | (next_sw[BIT_IE] & MASKABLE_REQ_I);
      // Only the accumulator-style names move; absolute names bypass this map
      if (next_sw[BIT_RSS]) begin
        MAP_A_O <= RS1_A; MAP_X_O <= RS1_X; MAP_B_O <= RS1_B; MAP_C_O <= RS1_C;
        MAP_AX_O <= RS1_AX; MAP_BC_O <= RS1_BC;
      end else begin
        MAP_A_O <= RS0_A; MAP_X_O <= RS0_X; MAP_B_O <= RS0_B; MAP_C_O <= RS0_C;
        MAP_AX_O <= RS0_AX; MAP_BC_O <= RS0_BC;
      end
    end
  end

  // ---------------------------------------------------------------
  // AHB-Lite slave: zero wait states, always OKAY
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      bus_we  <= 1'b0;
      bus_adr <= 8'h00;
    end else if (CE_I) begin
      bus_we  <= HSEL && HREADY && HTRANS == HTRANS_NONSEQ && HWRITE && HSIZE == HSIZE_WORD;
      bus_adr <= HADDR;
    end
  end

  // Read data registered in the address phase; unmapped reads return zero
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      HRDATA    <= 32'h00000000;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else if (CE_I) begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      if (HSEL && HREADY && HTRANS == HTRANS_NONSEQ && !HWRITE) begin
        case (HADDR)
          ADR_SW_LO: HRDATA <= {24'h000000, next_sw[7:0]};
          ADR_SW_HI: HRDATA <= {24'h000000, next_sw[15:8]};
          ADR_PC:    HRDATA <= {12'h000, pc};
          ADR_SP:    HRDATA <= {8'h00, sp};
          ADR_MAP:   HRDATA <= {29'h0000000, next_sw[BIT_BK2:BIT_BK0]};
          default:   HRDATA <= 32'h00000000;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign PC_O          = pc;
  assign STATUS_WORD_O = sw;
  assign STACK_PTR_O   = sp;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  AST_PC_INC: assert property (@(posedge CLK_I) disable iff (RESET_I)
    CE_I && FETCH_I && !BRANCH_I && !vec_pend |=> pc == $past(pc) + PC_W'($past(FETCH_LEN_I)))
    else $error("PC did not advance by fetch length");
  AST_PC_BRANCH: assert property (@(posedge CLK_I) disable iff (RESET_I)
    CE_I && BRANCH_I && !vec_pend |=> pc == $past(BRANCH_TARGET_I))
    else $error("PC did not take branch target");
  AST_PC_VECTOR: assert property (@(posedge CLK_I) disable iff (RESET_I)
    CE_I && vec_pend |=> pc == {PC_HI_RST, $past(RST_VECTOR_I)})
    else $error("PC not loaded from reset vector");
  AST_SW_CE_HOLD: assert property (@(posedge CLK_I) disable iff (RESET_I)
    !CE_I |=> $stable(sw))
    else $error("Status word changed while disabled");
  AST_SW_FIXED0: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (sw & ~SW_IMPL) == 16'h0000)
    else $error("Unused status bit set");
  AST_IE_ACK: assert property (@(posedge CLK_I) disable iff (RESET_I)
    CE_I && INT_ACK_I |=> !sw[BIT_IE])
    else $error("IE not cleared by acknowledge");
  AST_IE_EI: assert property (@(posedge CLK_I) disable iff (RESET_I)
    CE_I && EI_I && !DI_I && !INT_ACK_I && SEQ_I == SEQ_NONE |=> sw[BIT_IE])
    else $error("IE not set by enable");
  AST_PUSH: assert property (@(posedge CLK_I) disable iff (RESET_I)
    CE_I && SEQ_I == SEQ_PUSH && !SP_LOAD_I |=>
      STACK_WE_O && STACK_DATA_O == $past(sw) && sp == $past(sp) - SP_STEP)
    else $error("Push did not save status word");
  AST_CS_SAVE: assert property (@(posedge CLK_I) disable iff (RESET_I)
    CE_I && SEQ_I == SEQ_CS_SAVE |=> RP3_WE_O && STACK_DATA_O == $past(sw))
    else $error("Context save missed");
  AST_GATE: assert property (@(posedge CLK_I) disable iff (RESET_I)
    CE_I && !next_sw[BIT_IE] && !NMI_REQ_I && !MACRO_REQ_I |=> !INT_ACCEPT_O)
    else $error("Maskable interrupt accepted with IE low");
  AST_ARITH_PV: assert property (@(posedge CLK_I) disable iff (RESET_I)
    CE_I && ALU_I.valid && ALU_I.arith && SEQ_I == SEQ_NONE && !BIT_WE_I
      && !HALF_WE_LO_I && !bus_we |=> sw[BIT_PV] == $past(ALU_I.cy_msb ^ ALU_I.cy_out))
    else $error("Overflow flag wrong");
  AST_MAP: assert property (@(posedge CLK_I) disable iff (RESET_I)
    sw[BIT_RSS] |-> MAP_A_O == RS1_A && MAP_AX_O == RS1_AX)
    else $error("Register set map stale");

  COV_PUSH_POP: cover property (@(posedge CLK_I) SEQ_I == SEQ_PUSH ##[1:20] SEQ_I == SEQ_POP);
  COV_BRANCH:   cover property (@(posedge CLK_I) CE_I && BRANCH_I);
  COV_BUS_WR:   cover property (@(posedge CLK_I) bus_we && bus_adr == ADR_SW_HI);
  COV_ACCEPT:   cover property (@(posedge CLK_I) INT_ACCEPT_O && MASKABLE_REQ_I);

endmodule : ccsr_top
`default_nettype wire

/* File: verification/ccsr_partner.sv */
// Behavioural stack memory and fourth register pair beside the status block
`timescale 1ns/1ps
`default_nettype none
module ccsr_partner
  import ccsr_pkg::*;
(
  // Clock
  input  wire logic            clk_i,
  // Save side
  input  wire logic            stack_we_i,
  input  wire logic            rp3_we_i,
  input  wire logic [SP_W-1:0] sp_i,
  input  wire logic [SW_W-1:0] data_i,
  // Restore side
  input  wire ccsr_seq_t       seq_i,
  output logic      [SW_W-1:0] restore_o
);
  logic [SW_W-1:0] mem [256];
  logic [255:0]    full = '0;
  logic [SW_W-1:0] pair3;
  logic [SW_W-1:0] junk = 16'h9c31;
  logic [7:0]      slot;

  // Word slots follow the 2-byte step; 256 words cover any stack the tests use
  assign slot = sp_i[8:1];

  // Stores land at the pointer the block already moved down
  always @(posedge clk_i) begin
    junk <= junk + 16'h5a3d;
    if (stack_we_i) begin
      mem[slot]  <= data_i;
      full[slot] <= 1'b1;
    end
    if (rp3_we_i) pair3 <= data_i;
  end

  // Outside a restore the word keeps changing, so stale data never matches
  always_comb begin
    restore_o = junk;
    if (seq_i == SEQ_POP && full[slot]) restore_o = mem[slot];
    if (seq_i == SEQ_CS_RESTORE) restore_o = pair3;
  end
endmodule : ccsr_partner
`default_nettype wire

/* File: verification/cpu_control_status_registers_tb.sv */
// Self-checking testbench for the control and status register block
`timescale 1ns/1ps
`default_nettype none
module cpu_control_status_registers_tb;
  import ccsr_pkg::*;
  // ---------------------------------------------------------------
  // Signals and instances
  // ---------------------------------------------------------------
  logic        clk, rst, ce, fetch, br, hwl, hwh, bwe, bval, ei, di, bkwe, ack, spld;
  logic        nmi, macro, mreq, hsel, hwrite, swe, rp3we, acc, hrdy, hresp;
  logic [15:0] vec, restore, sw, sdat;
  logic [19:0] tgt, pc;
  logic [2:0]  flen, bk, hsize, ma, mx, mb, mc;
  logic [1:0]  htrans, max, mbc;
  logic [3:0]  bsel;
  logic [7:0]  hdat, haddr;
  logic [23:0] spv, sp;
  logic [31:0] hwdata, hrdata, rd;
  ccsr_flags_t flags;
  ccsr_alu_t   alu;
  ccsr_alu_t   av [6];
  logic [15:0] ev [6];
  ccsr_seq_t   seq;
  int          num_errors, n_checks;

  ccsr_top ccsr_top_i (
    .CLK_I(clk), .RESET_I(rst), .CE_I(ce), .RST_VECTOR_I(vec), .FETCH_I(fetch),
    .FETCH_LEN_I(flen), .BRANCH_I(br), .BRANCH_TARGET_I(tgt), .FLAGS_I(flags), .ALU_I(alu),
    .HALF_WE_LO_I(hwl), .HALF_WE_HI_I(hwh), .HALF_DATA_I(hdat), .BIT_WE_I(bwe),
    .BIT_SEL_I(bsel), .BIT_VAL_I(bval), .EI_I(ei), .DI_I(di), .BANK_WE_I(bkwe), .BANK_I(bk),
    .SEQ_I(seq), .INT_ACK_I(ack), .RESTORE_I(restore), .SP_LOAD_I(spld), .SP_I(spv),
    .NMI_REQ_I(nmi), .MACRO_REQ_I(macro), .MASKABLE_REQ_I(mreq), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
    .HREADY(hrdy), .HRDATA(hrdata), .HREADYOUT(hrdy), .HRESP(hresp), .PC_O(pc),
    .STATUS_WORD_O(sw), .STACK_PTR_O(sp), .STACK_WE_O(swe), .STACK_DATA_O(sdat),
    .RP3_WE_O(rp3we), .INT_ACCEPT_O(acc), .MAP_A_O(ma), .MAP_X_O(mx), .MAP_B_O(mb),
    .MAP_C_O(mc), .MAP_AX_O(max), .MAP_BC_O(mbc));

  ccsr_partner ccsr_partner_i (.clk_i(clk), .stack_we_i(swe), .rp3_we_i(rp3we), .sp_i(sp),
    .data_i(sdat), .seq_i(seq), .restore_o(restore));

  // 100 ns clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic complete_run;
    if (num_errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  // Strobes act on one edge and drop, so a pulse is never taken twice
  task automatic go;
    @(posedge clk);
    {fetch, br, hwl, hwh, bwe, ei, di, bkwe, ack, spld} <= '0;
    flags <= '0;
    alu <= '0;
    seq <= SEQ_NONE;
    #1;
  endtask : go

  // Single word transfer; waits on ready instead of assuming zero wait states
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= HSIZE_WORD;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
    #1;
  endtask : ahb

  // Hang guard, far beyond the few hundred cycles the sequence needs
  initial begin
    #400000;
    num_errors++;
    complete_run;
  end

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    {rst, ce, hsel} = 3'b111;
    {fetch, br, hwl, hwh, bwe, ei, di, bkwe, ack, spld, nmi, macro, mreq} = '0;
    {flen, tgt, hdat, bsel, bval, bk, spv, haddr, htrans, hwrite, hsize, hwdata} = '0;
    flags = '0;
    alu = '0;
    seq = SEQ_NONE;
    vec = 16'hbeef;
    num_errors = 0;
    n_checks = 0;
    // Flag results: add 78+69, add fb+f0, zero, 16-bit shift, odd byte, odd word
    av[0] = '{1'b1, 1'b0, 1'b1, 1'b0, 16'h00e1, 1'b0, 1'b1, 1'b1};
    av[1] = '{1'b1, 1'b0, 1'b1, 1'b0, 16'h00eb, 1'b1, 1'b1, 1'b0};
    av[2] = '{1'b1, 1'b0, 1'b0, 1'b0, 16'h0000, 1'b0, 1'b0, 1'b0};
    av[3] = '{1'b1, 1'b1, 1'b0, 1'b1, 16'h8103, 1'b1, 1'b0, 1'b0};
    av[4] = '{1'b1, 1'b0, 1'b0, 1'b0, 16'h0007, 1'b0, 1'b0, 1'b0};
    av[5] = '{1'b1, 1'b1, 1'b0, 1'b0, 16'h0103, 1'b0, 1'b0, 1'b0};
    ev = '{16'hf09c, 16'hf089, 16'hf04c, 16'hf08d, 16'hf008, 16'hf008};
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    go;
    go;
    chk(pc, 20'h0beef);
    chk(sw, 16'h0000);
    chk({ma, mx, mb, mc, max, mbc}, 16'h21a1);
    // Counter steps, branch load and 20-bit wrap
    @(posedge clk);
    fetch <= 1'b1;
    flen <= 3'h3;
    go;
    chk(pc, 20'h0bef2);
    @(posedge clk);
    br <= 1'b1;
    tgt <= 20'hffffe;
    go;
    chk(pc, 20'hffffe);
    @(posedge clk);
    fetch <= 1'b1;
    flen <= 3'h5;
    go;
    ahb(1'b0, ADR_PC, 32'h0);
    chk(rd, 32'h00003);
    ahb(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    // Halves: unused bits stay zero and the fixed-zero bit refuses a one
    @(posedge clk);
    hwh <= 1'b1;
    hwl <= 1'b1;
    hdat <= 8'hff;
    go;
    chk(sw, 16'hf0fd);
    ahb(1'b1, ADR_SW_LO, 32'h0);
    ahb(1'b0, ADR_SW_HI, 32'h0);
    chk(rd, 32'hf0);
    ahb(1'b1, ADR_SW_HI, 32'h0);
    chk(sw, 16'h0);
    // Every bit set and cleared on its own
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      bwe <= 1'b1;
      bsel <= 4'(i);
      bval <= 1'b1;
      go;
      chk(sw, (16'h1 << i) & 16'hf0fd);
      @(posedge clk);
      bwe <= 1'b1;
      bval <= 1'b0;
      go;
    end
    // Set select 1 remaps the named registers, then back to 0
    for (int s = 1; s >= 0; s--) begin
      @(posedge clk);
      bwe <= 1'b1;
      bsel <= 4'h5;
      bval <= s[0];
      go;
      go;
      chk({ma, mx, mb, mc, max, mbc}, s ? 16'hb3eb : 16'h21a1);
    end
    // All eight banks
    for (int b = 0; b < 8; b++) begin
      @(posedge clk);
      bkwe <= 1'b1;
      bk <= 3'(b);
      go;
      chk(sw, {1'b0, 3'(b), 12'h0});
      ahb(1'b0, ADR_MAP, 32'h0);
      chk(rd, 32'(b));
    end
    @(posedge clk);
    bwe <= 1'b1;
    bsel <= 4'hf;
    bval <= 1'b1;
    go;
    chk(sw, 16'hf000);
    // Interrupt enable against each request source
    @(posedge clk);
    ei <= 1'b1;
    mreq <= 1'b1;
    go;
    go;
    chk(sw, 16'hf008);
    chk(acc, 1'b1);
    @(posedge clk);
    di <= 1'b1;
    go;
    go;
    chk(sw, 16'hf000);
    chk(acc, 1'b0);
    @(posedge clk);
    nmi <= 1'b1;
    go;
    go;
    chk(acc, 1'b1);
    @(posedge clk);
    nmi <= 1'b0;
    macro <= 1'b1;
    go;
    go;
    chk(acc, 1'b1);
    @(posedge clk);
    macro <= 1'b0;
    mreq <= 1'b0;
    ei <= 1'b1;
    go;
    // Flags from results; enable, user flag and bank must hold
    for (int k = 0; k < 6; k++) begin
      @(posedge clk);
      alu <= av[k];
      go;
      chk(sw, ev[k]);
    end
    @(posedge clk);
    flags.cy_we <= 1'b1;
    flags.cy <= 1'b1;
    go;
    chk(sw, 16'hf009);
    // Interrupt push and pop through the stack
    @(posedge clk);
    spld <= 1'b1;
    spv <= 24'h001000;
    go;
    @(posedge clk);
    seq <= SEQ_PUSH;
    ack <= 1'b1;
    go;
    chk({swe, sdat}, {1'b1, 16'hf009});
    chk(sp, 24'h000ffe);
    chk(sw, 16'hf001);
    @(posedge clk);
    hwl <= 1'b1;
    hdat <= 8'h00;
    go;
    chk(swe, 1'b0);
    @(posedge clk);
    seq <= SEQ_POP;
    go;
    chk(sw, 16'hf009);
    chk(sp, 24'h001000);
    // Context switch save and restore leave the stack alone
    @(posedge clk);
    seq <= SEQ_CS_SAVE;
    go;
    chk({rp3we, sdat}, {1'b1, 16'hf009});
    @(posedge clk);
    hwh <= 1'b1;
    go;
    @(posedge clk);
    seq <= SEQ_CS_RESTORE;
    go;
    chk(sw, 16'hf009);
    chk(sp, 24'h001000);
    // Enable low freezes every register even with strobes raised
    @(posedge clk);
    ce <= 1'b0;
    fetch <= 1'b1;
    flen <= 3'h2;
    bwe <= 1'b1;
    bsel <= 4'hf;
    bval <= 1'b0;
    seq <= SEQ_PUSH;
    go;
    chk(pc, 20'h00003);
    chk(sw, 16'hf009);
    chk(sp, 24'h001000);
    chk(swe, 1'b0);
    @(posedge clk);
    ce <= 1'b1;
    go;
    // Second reset in mid-run with a new vector
    @(posedge clk);
    rst <= 1'b1;
    vec <= 16'h1234;
    go;
    chk(sw, 16'h0);
    @(posedge clk);
    rst <= 1'b0;
    go;
    go;
    chk(pc, 20'h01234);
    complete_run;
  end
endmodule : cpu_control_status_registers_tb
`default_nettype wire
